// >>> src/bfp_defines.vh
// Purpose: constants for the buck fault and power-good logic
// Assumes: 200 MHz core clock, APB register port with 32-bit data
// Notes: times are kept in microseconds, cycle counts derive from them
`ifndef BFP_DEFINES_VH
`define BFP_DEFINES_VH

// ==========================================================
// clock and timing
`define BFP_CLK_MHZ 200
`define BFP_UV_DELAY_US 64
`define BFP_PG_DELAY_US 5
`define BFP_EN_FILTER_US 2
`define BFP_UV_DELAY_CYC 16'h3200

// ==========================================================
// register byte offsets
`define BFP_ADDR_CTRL 8'h00
`define BFP_ADDR_STATUS 8'h04
`define BFP_ADDR_IRQ_STAT 8'h08
`define BFP_ADDR_IRQ_MASK 8'h0c

// ==========================================================
// ctrl fields and reset values
`define BFP_CTRL_SW_OFF 0
`define BFP_CTRL_RESET 1'b0
`define BFP_IRQ_MASK_RESET 5'h00

// ==========================================================
// status fields
`define BFP_ST_STATE_LSB 0
`define BFP_ST_POWER_GOOD_FLAG 5
`define BFP_ST_UV_LATCH 6
`define BFP_ST_OC_START 7
`define BFP_ST_CLAMP 8
`define BFP_ST_EXTREF 9
`define BFP_ST_EN 10

// ==========================================================
// interrupt event bits
`define BFP_EV_LATCHOFF 0
`define BFP_EV_OVDET 1
`define BFP_EV_PGFALL 2
`define BFP_EV_VALLEY 3
`define BFP_EV_NEGLIM 4
`define BFP_EV_WIDTH 5

// ==========================================================
// synchroniser bit positions
`define BFP_SY_EN 0
`define BFP_SY_UV 1
`define BFP_SY_OV 2
`define BFP_SY_VALLEY 3
`define BFP_SY_NEG 4
`define BFP_SY_SSDONE 5
`define BFP_SY_EXTREF 6
`define BFP_SY_RLOW 7
`define BFP_SY_WIDTH 8

`endif

// >>> src/bfp_fault_pg_logic.v
// Purpose: fault supervision, switch overrides and power-good latch
// Assumes: comparator levels are asynchronous, loop requests synchronous
// Notes: registers reached over APB with zero wait states
`timescale 1ns/1ps
`include "bfp_defines.vh"

// Overview of operation
// - in off phase, low side stays on while current exceeds valley limit
// - feedback below 80 percent starts 64 us timer, then both switches latch off
// - after undervoltage latch-off switches stay off until supply reset or enable toggle
// - current limit during start-up finishes soft start, then undervoltage latch-off
// - limit resistance below 3.74 kOhm selects internal fixed current clamp
// - at negative limit low side off, high side on for one on-time
// - power-good function inactive until soft start completes
// - power-good rises only after soft start with output inside window
// - feedback below 80 or above 116 percent latches power-good low after 5 us
// - power-good thresholds follow external reference when one is present
// - latched-low power-good released only by enable toggle or supply reset
// - undervoltage detection ignored until soft start finishes
// - after soft start, above 116 percent high side latched off, low side on, discharge cycling
// - discharge cycling runs until 64 us below undervoltage, then latch off
// - latched overvoltage fault cleared only by supply reset or enable toggle
// - output back above undervoltage threshold resets undervoltage timer
// - enable filtered 2 us; long low shuts down, rise restarts start-up
module bfp_fault_pg_logic
#(
  parameter [15:0] UV_DELAY_CYC = `BFP_UV_DELAY_CYC
)
(
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire enablePin,
  input wire fbUnderUv,
  input wire fbOverOv,
  input wire lsOverValley,
  input wire lsNegLimit,
  input wire softStartDone,
  input wire extRefDetect,
  input wire limitResLow,
  input wire loopHsRequest,
  input wire onTimeDone,
  output reg hsDrive_ff,
  output reg lsDrive_ff,
  output reg startupRestart_ff,
  output reg internalClampSel_ff,
  output reg pgRefExternal_ff,
  output wire powerGoodOut,
  output reg powerGoodOe_ff,
  output wire irq
);

  // ==========================================================
  // constants
  localparam integer PG_CYC_I = `BFP_PG_DELAY_US * `BFP_CLK_MHZ;
  localparam integer EN_CYC_I = `BFP_EN_FILTER_US * `BFP_CLK_MHZ;
  localparam [15:0] PG_CYC = PG_CYC_I[15:0];
  localparam [15:0] EN_CYC = EN_CYC_I[15:0];

  localparam [4:0] ST_OFF = 5'h01;
  localparam [4:0] ST_SOFT = 5'h02;
  localparam [4:0] ST_RUN = 5'h04;
  localparam [4:0] ST_OVDIS = 5'h08;
  localparam [4:0] ST_LATCH = 5'h10;

  // ==========================================================
  // declarations
  reg [`BFP_SY_WIDTH-1:0] sync1_ff, sync2_ff;
  reg [15:0] enCnt_ff, nxt_enCnt, uvCnt_ff, nxt_uvCnt, pgCnt_ff, nxt_pgCnt;
  reg [4:0] state_ff, nxt_state;
  reg enFilt_ff, nxt_enFilt, pgHigh_ff, nxt_pgHigh, pgLatchedLow_ff, nxt_pgLatchedLow;
  reg ocStart_ff, nxt_ocStart, uvLatch_ff, nxt_uvLatch, valleyHold_ff, nxt_valleyHold;
  reg negPulse_ff, nxt_negPulse, nxt_hs, nxt_ls, swOff_ff;
  reg [`BFP_EV_WIDTH-1:0] irqStat_ff, irqMask_ff, events;
  reg [31:0] nxt_prdata;
  wire enSync, uvSync, ovSync, valleySync, negSync, ssDoneSync, enRise, active;
  wire uvExpired, pgExpired, outOfWindow, apbAccess, apbWrite, apbRead, addrHit;

  // ==========================================================
  // input synchronisers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_ff <= {`BFP_SY_WIDTH{1'b0}};
      sync2_ff <= {`BFP_SY_WIDTH{1'b0}};
    end
    else
    begin
      sync1_ff <= {limitResLow, extRefDetect, softStartDone, lsNegLimit,
                   lsOverValley, fbOverOv, fbUnderUv, enablePin};
      sync2_ff <= sync1_ff;
    end
  end

  assign enSync = sync2_ff[`BFP_SY_EN];
  assign uvSync = sync2_ff[`BFP_SY_UV];
  assign ovSync = sync2_ff[`BFP_SY_OV];
  assign valleySync = sync2_ff[`BFP_SY_VALLEY];
  assign negSync = sync2_ff[`BFP_SY_NEG];
  assign ssDoneSync = sync2_ff[`BFP_SY_SSDONE];

  // ==========================================================
  // enable filter
  always @*
  begin
    nxt_enFilt = enFilt_ff;
    nxt_enCnt = 16'h0000;
    if (enSync != enFilt_ff)
    begin
      if (enCnt_ff == EN_CYC)
        nxt_enFilt = enSync;
      else
        nxt_enCnt = enCnt_ff + 16'h0001;
    end
  end

  assign enRise = nxt_enFilt & ~enFilt_ff;

  // ==========================================================
  // delay timers
  assign active = (state_ff == ST_RUN) || (state_ff == ST_OVDIS);
  assign uvExpired = uvSync && (uvCnt_ff == UV_DELAY_CYC);
  assign outOfWindow = uvSync | ovSync;
  assign pgExpired = outOfWindow && (pgCnt_ff == PG_CYC);

  always @*
  begin
    nxt_uvCnt = 16'h0000;
    if (active && uvSync)
    begin
      if (uvCnt_ff == UV_DELAY_CYC)
        nxt_uvCnt = uvCnt_ff;
      else
        nxt_uvCnt = uvCnt_ff + 16'h0001;
    end
    nxt_pgCnt = 16'h0000;
    if (pgHigh_ff && outOfWindow)
    begin
      if (pgCnt_ff == PG_CYC)
        nxt_pgCnt = pgCnt_ff;
      else
        nxt_pgCnt = pgCnt_ff + 16'h0001;
    end
  end

  // ==========================================================
  // sequencing state machine
  always @*
  begin
    nxt_state = state_ff;
    nxt_ocStart = ocStart_ff;
    nxt_uvLatch = uvLatch_ff;
    case (state_ff)
      ST_OFF:
      begin
        nxt_ocStart = 1'b0;
        nxt_uvLatch = 1'b0;
        if (enFilt_ff)
          nxt_state = ST_SOFT;
      end
      ST_SOFT:
      begin
        if (valleySync)
          nxt_ocStart = 1'b1;
        if (ssDoneSync)
        begin
          if (nxt_ocStart)
          begin
            nxt_state = ST_LATCH;
            nxt_uvLatch = 1'b1;
          end
          else
            nxt_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (uvExpired)
        begin
          nxt_state = ST_LATCH;
          nxt_uvLatch = 1'b1;
        end
        else if (ovSync)
          nxt_state = ST_OVDIS;
      end
      ST_OVDIS:
      begin
        if (uvExpired)
        begin
          nxt_state = ST_LATCH;
          nxt_uvLatch = 1'b1;
        end
      end
      ST_LATCH:
        nxt_state = ST_LATCH;
      default:
        nxt_state = ST_OFF;
    endcase
    if (!enFilt_ff)
      nxt_state = ST_OFF;
  end

  // ==========================================================
  // switch override logic
  always @*
  begin
    nxt_valleyHold = 1'b0;
    nxt_negPulse = 1'b0;
    nxt_hs = 1'b0;
    nxt_ls = 1'b0;
    if ((state_ff == ST_SOFT || active) && !swOff_ff)
    begin
      if (negPulse_ff)
        nxt_negPulse = !onTimeDone;
      else
        nxt_negPulse = lsDrive_ff && negSync;
      nxt_valleyHold = lsDrive_ff && valleySync && !nxt_negPulse;
      if (nxt_negPulse)
        nxt_hs = 1'b1;
      else if (state_ff == ST_OVDIS)
        nxt_ls = 1'b1;
      else if (nxt_valleyHold)
        nxt_ls = 1'b1;
      else
      begin
        nxt_hs = loopHsRequest;
        nxt_ls = !loopHsRequest;
      end
    end
  end

  // ==========================================================
  // power-good latch
  always @*
  begin
    nxt_pgHigh = pgHigh_ff;
    nxt_pgLatchedLow = pgLatchedLow_ff;
    if (state_ff == ST_OFF)
    begin
      nxt_pgHigh = 1'b0;
      nxt_pgLatchedLow = 1'b0;
    end
    else if (!active)
      nxt_pgHigh = 1'b0;
    else if (pgHigh_ff)
    begin
      if (pgExpired)
      begin
        nxt_pgHigh = 1'b0;
        nxt_pgLatchedLow = 1'b1;
      end
    end
    else if (!pgLatchedLow_ff && ssDoneSync && !outOfWindow)
      nxt_pgHigh = 1'b1;
  end

  // ==========================================================
  // core registers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      enFilt_ff <= 1'b0;
      enCnt_ff <= 16'h0000;
      state_ff <= ST_OFF;
      uvCnt_ff <= 16'h0000;
      pgCnt_ff <= 16'h0000;
      pgHigh_ff <= 1'b0;
      pgLatchedLow_ff <= 1'b0;
      ocStart_ff <= 1'b0;
      uvLatch_ff <= 1'b0;
      valleyHold_ff <= 1'b0;
      negPulse_ff <= 1'b0;
      hsDrive_ff <= 1'b0;
      lsDrive_ff <= 1'b0;
      startupRestart_ff <= 1'b0;
      internalClampSel_ff <= 1'b0;
      pgRefExternal_ff <= 1'b0;
      powerGoodOe_ff <= 1'b1;
    end
    else
    begin
      enFilt_ff <= nxt_enFilt;
      enCnt_ff <= nxt_enCnt;
      state_ff <= nxt_state;
      uvCnt_ff <= nxt_uvCnt;
      pgCnt_ff <= nxt_pgCnt;
      pgHigh_ff <= nxt_pgHigh;
      pgLatchedLow_ff <= nxt_pgLatchedLow;
      ocStart_ff <= nxt_ocStart;
      uvLatch_ff <= nxt_uvLatch;
      valleyHold_ff <= nxt_valleyHold;
      negPulse_ff <= nxt_negPulse;
      hsDrive_ff <= nxt_hs;
      lsDrive_ff <= nxt_ls;
      startupRestart_ff <= enRise;
      internalClampSel_ff <= sync2_ff[`BFP_SY_RLOW];
      pgRefExternal_ff <= sync2_ff[`BFP_SY_EXTREF];
      powerGoodOe_ff <= !nxt_pgHigh;
    end
  end

  // open drain: only ever pulls low
  assign powerGoodOut = 1'b0;

  // ==========================================================
  // apb slave
  assign pready = 1'b1;
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = apbAccess && !pwrite;
  assign addrHit = (paddr == `BFP_ADDR_CTRL) || (paddr == `BFP_ADDR_STATUS) ||
                   (paddr == `BFP_ADDR_IRQ_STAT) || (paddr == `BFP_ADDR_IRQ_MASK);
  assign pslverr = apbAccess && !addrHit;

  always @*
  begin
    nxt_prdata = 32'h00000000;
    case (paddr)
      `BFP_ADDR_CTRL:
        nxt_prdata[`BFP_CTRL_SW_OFF] = swOff_ff;
      `BFP_ADDR_STATUS:
      begin
        nxt_prdata[`BFP_ST_STATE_LSB+4:`BFP_ST_STATE_LSB] = state_ff;
        nxt_prdata[`BFP_ST_POWER_GOOD_FLAG] = pgHigh_ff;
        nxt_prdata[`BFP_ST_UV_LATCH] = uvLatch_ff;
        nxt_prdata[`BFP_ST_OC_START] = ocStart_ff;
        nxt_prdata[`BFP_ST_CLAMP] = internalClampSel_ff;
        nxt_prdata[`BFP_ST_EXTREF] = pgRefExternal_ff;
        nxt_prdata[`BFP_ST_EN] = enFilt_ff;
      end
      `BFP_ADDR_IRQ_STAT:
        nxt_prdata[`BFP_EV_WIDTH-1:0] = irqStat_ff;
      `BFP_ADDR_IRQ_MASK:
        nxt_prdata[`BFP_EV_WIDTH-1:0] = irqMask_ff;
      default:
        nxt_prdata = 32'h00000000;
    endcase
  end

  // read data captured in setup phase, held through access
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= pwrite ? 32'h00000000 : nxt_prdata;
    else if (!psel)
      prdata <= 32'h00000000;
  end

  // ==========================================================
  // interrupt events
  always @*
  begin
    events = {`BFP_EV_WIDTH{1'b0}};
    events[`BFP_EV_LATCHOFF] = (nxt_state == ST_LATCH) && (state_ff != ST_LATCH);
    events[`BFP_EV_OVDET] = (nxt_state == ST_OVDIS) && (state_ff != ST_OVDIS);
    events[`BFP_EV_PGFALL] = pgHigh_ff && !nxt_pgHigh;
    events[`BFP_EV_VALLEY] = nxt_valleyHold && !valleyHold_ff;
    events[`BFP_EV_NEGLIM] = nxt_negPulse && !negPulse_ff;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      swOff_ff <= `BFP_CTRL_RESET;
      irqMask_ff <= `BFP_IRQ_MASK_RESET;
      irqStat_ff <= {`BFP_EV_WIDTH{1'b0}};
    end
    else
    begin
      if (apbWrite && paddr == `BFP_ADDR_CTRL)
        swOff_ff <= pwdata[`BFP_CTRL_SW_OFF];
      if (apbWrite && paddr == `BFP_ADDR_IRQ_MASK)
        irqMask_ff <= pwdata[`BFP_EV_WIDTH-1:0];
      if (apbRead && paddr == `BFP_ADDR_IRQ_STAT)
        irqStat_ff <= (irqStat_ff & ~prdata[`BFP_EV_WIDTH-1:0]) | events;
      else
        irqStat_ff <= irqStat_ff | events;
    end
  end

  assign irq = |(irqStat_ff & irqMask_ff);

endmodule

// >>> testbench/bfp_fault_pg_assertions.sv
// Purpose: port checks for the fault and power-good block
// Assumes: one clock, async active-high reset
// Notes: synced copies lag their inputs by three cycles
`timescale 1ns/1ps
`include "bfp_defines.vh"
module bfp_fault_pg_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic enablePin,
  input wire logic fbUnderUv,
  input wire logic fbOverOv,
  input wire logic softStartDone,
  input wire logic limitResLow,
  input wire logic extRefDetect,
  input wire logic hsDrive_ff,
  input wire logic lsDrive_ff,
  input wire logic internalClampSel_ff,
  input wire logic pgRefExternal_ff,
  input wire logic powerGoodOe_ff,
  input wire logic startupRestart_ff
);
  // ==========
  // helper counters
  logic [2:0] upCnt_ff;
  logic [10:0] vioCnt_ff;
  logic [9:0] enHiCnt_ff;
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      upCnt_ff <= 3'h0;
      vioCnt_ff <= 11'h000;
      enHiCnt_ff <= 10'h000;
    end
    else
    begin
      upCnt_ff <= (upCnt_ff == 3'h7) ? upCnt_ff : upCnt_ff + 3'h1;
      vioCnt_ff <= ((fbUnderUv || fbOverOv) && !powerGoodOe_ff) ? vioCnt_ff + 11'h001 : 11'h000;
      enHiCnt_ff <= !enablePin ? 10'h000 : enHiCnt_ff + {9'h000, enHiCnt_ff != 10'h3ff};
    end
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence bad_acc_s;
    psel && penable && !(paddr inside {`BFP_ADDR_CTRL, `BFP_ADDR_STATUS,
      `BFP_ADDR_IRQ_STAT, `BFP_ADDR_IRQ_MASK});
  endsequence
  sequence mask_clear_s;
    psel && penable && pwrite && paddr == `BFP_ADDR_IRQ_MASK && pwdata[4:0] == 5'h00;
  endsequence
  bus_error_a:
    assert property (bad_acc_s |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mask_off_a:
    assert property (mask_clear_s |=> !irq)
    else $error("irq up with all masked");
  clamp_copy_a:
    assert property (upCnt_ff == 3'h7 |-> internalClampSel_ff == $past(limitResLow, 3))
    else $error("clamp select not a synced copy");
  ext_ref_a:
    assert property (upCnt_ff == 3'h7 |-> pgRefExternal_ff == $past(extRefDetect, 3))
    else $error("reference select not a synced copy");
  pg_rise_a:
    assert property ($fell(powerGoodOe_ff) |-> $past(softStartDone, 3)
      && !$past(fbUnderUv, 3) && !$past(fbOverOv, 3))
    else $error("power good released outside window");
  pg_latch_a:
    assert property (vioCnt_ff <= 11'h3f0)
    else $error("power good not latched low in time");
  restart_filter_a:
    assert property (startupRestart_ff |-> enHiCnt_ff >= 10'h180 ##1 !startupRestart_ff[*8])
    else $error("restart without filtered enable");
  restart_pg_a:
    assert property (startupRestart_ff |-> powerGoodOe_ff)
    else $error("power good active at restart");
  no_overlap_a:
    assert property (!(hsDrive_ff && lsDrive_ff))
    else $error("both switches on");
endmodule

bind bfp_fault_pg_logic bfp_fault_pg_assertions sva (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .irq(irq),
  .enablePin(enablePin), .fbUnderUv(fbUnderUv), .fbOverOv(fbOverOv),
  .softStartDone(softStartDone), .limitResLow(limitResLow), .extRefDetect(extRefDetect),
  .hsDrive_ff(hsDrive_ff), .lsDrive_ff(lsDrive_ff), .internalClampSel_ff(internalClampSel_ff),
  .pgRefExternal_ff(pgRefExternal_ff), .powerGoodOe_ff(powerGoodOe_ff),
  .startupRestart_ff(startupRestart_ff));

// >>> testbench/bfp_ctrl_model.sv
// Purpose: system controller model, owns enable, reads power good
// Assumes: power-good line pulled up when released
// Notes: toggles held longer than the enable filter
`timescale 1ns/1ps
module bfp_ctrl_model (
  input wire logic clk,
  input wire logic powerGoodOut,
  input wire logic powerGoodOe_ff,
  output logic enablePin,
  output wire logic pgLine
);
  // ==========
  // open-drain line with pull-up
  assign pgLine = powerGoodOe_ff ? powerGoodOut : 1'b1;
  initial enablePin = 1'b0;
  // ==========
  // enable driving
  task drive_en(input logic lvl, input int n);
    @(posedge clk);
    enablePin <= lvl;
    repeat (n) @(posedge clk);
  endtask
  task retoggle();
    drive_en(1'b0, 500);
    drive_en(1'b1, 500);
  endtask
endmodule

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the fault and power-good block
// Assumes: 200 MHz clk, reset held 8 cycles, short undervoltage delay
// Notes: controller model owns enable and the power-good line
`timescale 1ns/1ps
`include "bfp_defines.vh"
module tb_top;
  // ==========
  // signals
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, enablePin, pgLine, hs, ls, clampSel, refExt, oe, pgOut;
  logic fbUnderUv = 1'b0, fbOverOv = 1'b0, lsOverValley = 1'b0, lsNegLimit = 1'b0;
  logic softStartDone = 1'b0, extRefDetect = 1'b1, limitResLow = 1'b1;
  logic loopHsRequest = 1'b0, onTimeDone = 1'b0;
  int fail_count = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  bfp_fault_pg_logic #(.UV_DELAY_CYC(16'h0014)) uut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enablePin(enablePin), .fbUnderUv(fbUnderUv), .fbOverOv(fbOverOv),
    .lsOverValley(lsOverValley), .lsNegLimit(lsNegLimit), .softStartDone(softStartDone),
    .extRefDetect(extRefDetect), .limitResLow(limitResLow), .loopHsRequest(loopHsRequest),
    .onTimeDone(onTimeDone), .hsDrive_ff(hs), .lsDrive_ff(ls), .startupRestart_ff(),
    .internalClampSel_ff(clampSel), .pgRefExternal_ff(refExt), .powerGoodOut(pgOut),
    .powerGoodOe_ff(oe), .irq(irq));
  bfp_ctrl_model ctrl (.clk(clk), .powerGoodOut(pgOut), .powerGoodOe_ff(oe),
    .enablePin(enablePin), .pgLine(pgLine));
  // ==========
  // tasks
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task st(input logic [4:0] s);
    apb(`BFP_ADDR_STATUS, 1'b0, 32'h0);
    chk({27'h0, r[4:0]}, {27'h0, s});
  endtask
  task pulse_neg();
    lsNegLimit <= 1'b1;
    cyc(2);
    lsNegLimit <= 1'b0;
    cyc(4);
    chk({hs, ls}, 2'b10);
    onTimeDone <= 1'b1;
    cyc(1);
    onTimeDone <= 1'b0;
    cyc(3);
    chk({hs, ls}, 2'b01);
  endtask
  task complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // watchdog
  initial
  begin
    cyc(20000);
    fail_count++;
    complete_run();
  end
  // ==========
  // tests
  initial
  begin
    cyc(8);
    reset <= 1'b0;
    apb(`BFP_ADDR_CTRL, 1'b0, 32'h0);
    chk(r, 32'h0);
    st(5'h01);
    chk(pgLine, 1'b0);
    apb(8'h10, 1'b1, 32'h1);
    chk({r[30:0], e}, 32'h1);
    apb(`BFP_ADDR_IRQ_MASK, 1'b1, 32'hffffffff);
    apb(`BFP_ADDR_IRQ_MASK, 1'b0, 32'h0);
    chk(r, 32'h1f);
    ctrl.drive_en(1'b1, 450);
    st(5'h02);
    chk(pgLine, 1'b0);
    chk({clampSel, refExt}, 2'b11);
    softStartDone <= 1'b1;
    cyc(10);
    st(5'h04);
    chk(pgLine, 1'b1);
    lsOverValley <= 1'b1;
    cyc(5);
    loopHsRequest <= 1'b1;
    cyc(5);
    chk({hs, ls}, 2'b01);
    lsOverValley <= 1'b0;
    cyc(6);
    chk({hs, ls}, 2'b10);
    apb(`BFP_ADDR_CTRL, 1'b1, 32'h1);
    cyc(2);
    chk({hs, ls}, 2'b00);
    apb(`BFP_ADDR_CTRL, 1'b1, 32'h0);
    loopHsRequest <= 1'b0;
    cyc(3);
    pulse_neg();
    chk(irq, 1'b1);
    apb(`BFP_ADDR_IRQ_MASK, 1'b1, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    apb(`BFP_ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(r, 32'h18);
    apb(`BFP_ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(r, 32'h0);
    apb(`BFP_ADDR_IRQ_MASK, 1'b1, 32'h1f);
    fbUnderUv <= 1'b1;
    cyc(12);
    fbUnderUv <= 1'b0;
    cyc(4);
    fbUnderUv <= 1'b1;
    cyc(12);
    fbUnderUv <= 1'b0;
    st(5'h04);
    fbUnderUv <= 1'b1;
    cyc(30);
    fbUnderUv <= 1'b0;
    st(5'h10);
    chk({hs, ls}, 2'b00);
    cyc(100);
    st(5'h10);
    chk(irq, 1'b1);
    apb(`BFP_ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(r, 32'h5);
    ctrl.drive_en(1'b0, 100);
    ctrl.drive_en(1'b1, 20);
    st(5'h10);
    ctrl.retoggle();
    st(5'h04);
    chk(pgLine, 1'b1);
    fbOverOv <= 1'b1;
    cyc(10);
    st(5'h08);
    chk({hs, ls}, 2'b01);
    pulse_neg();
    cyc(850);
    chk(pgLine, 1'b1);
    cyc(200);
    chk(pgLine, 1'b0);
    fbOverOv <= 1'b0;
    cyc(10);
    chk(pgLine, 1'b0);
    st(5'h08);
    fbUnderUv <= 1'b1;
    cyc(40);
    st(5'h10);
    fbUnderUv <= 1'b0;
    cyc(50);
    st(5'h10);
    softStartDone <= 1'b0;
    limitResLow <= 1'b0;
    extRefDetect <= 1'b0;
    ctrl.retoggle();
    fbUnderUv <= 1'b1;
    cyc(40);
    st(5'h02);
    chk(clampSel, 1'b0);
    chk(refExt, 1'b0);
    fbUnderUv <= 1'b0;
    lsOverValley <= 1'b1;
    cyc(5);
    lsOverValley <= 1'b0;
    softStartDone <= 1'b1;
    cyc(10);
    apb(`BFP_ADDR_STATUS, 1'b0, 32'h0);
    chk(r & 32'hdf, 32'hd0);
    complete_run();
  end
endmodule
